//--- dv/pmrs_adc_model.sv
`timescale 1ns/10ps
module pmrs_adc_model (
    input  wire logic        core_clk,    // clock
    input  wire logic        rst_n,       // reset, low
    input  wire logic        convStart,   // sample request
    input  wire logic [3:0]  delayCyc,    // reply delay
    input  wire logic [17:0] shuntIn,     // next shunt
    input  wire logic [15:0] busIn,       // next bus
    input  wire logic [11:0] tempIn,      // next temp
    output logic             sampleValid, // sample pulse
    output logic [17:0]      sampleShunt, // shunt data
    output logic [15:0]      sampleBus,   // bus data
    output logic [11:0]      sampleTemp   // temp data
);
    logic [3:0] cnt;
    logic       busy;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt         <= 4'h0;
            busy        <= 1'b0;
            sampleValid <= 1'b0;
            sampleShunt <= 18'h00000;
            sampleBus   <= 16'h0000;
            sampleTemp  <= 12'h000;
        end else begin
            sampleValid <= 1'b0;
            // data is only good with the pulse; scramble it otherwise
            sampleShunt <= ~sampleShunt;
            sampleBus   <= ~sampleBus;
            sampleTemp  <= ~sampleTemp;
            if (convStart) begin
                busy <= 1'b1;
                cnt  <= delayCyc;
            end else if (busy && cnt == 4'h0) begin
                busy        <= 1'b0;
                sampleValid <= 1'b1;
                sampleShunt <= shuntIn;
                sampleBus   <= busIn;
                sampleTemp  <= tempIn;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

//--- dv/pmrs_result_scaling_monitor.sv
`timescale 1ns/10ps
module pmrs_result_scaling_monitor #(
    parameter int CYC_PER_US = 1
) (
    input wire logic               core_clk,    // clock
    input wire logic               rst_n,       // reset
    input wire logic               enable,      // run
    input wire logic [2:0]         convTimeSel, // conv time
    input wire logic [2:0]         avgSel,      // averaging
    input wire logic [14:0]        shuntCal,    // calibration
    input wire logic signed [11:0] temperatureLimitThreshold, // limit
    input wire logic [15:0]        powerLimitThreshold,       // limit
    input wire logic               convStart,   // request
    input wire logic               sampleValid, // sample
    input wire logic signed [11:0] sampleTemp,  // raw temp
    input wire logic signed [15:0] shuntVoltageResult,   // shunt
    input wire logic signed [11:0] dieTemperatureResult, // temp
    input wire logic signed [15:0] currentResult, // current
    input wire logic [23:0]        powerResult, // power
    input wire logic               resultValid, // done
    input wire logic               overTemperature, // flag
    input wire logic               overPower    // flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] gap;
    logic        clean;
    // period only judged when enable and code held the whole span
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap   <= 16'h0000;
            clean <= 1'b0;
        end else begin
            gap   <= convStart ? 16'h0001 : gap + 16'h0001;
            clean <= convStart || (clean && enable && $stable(convTimeSel));
        end
    end
    conv_period_a: assert property (
        convStart && clean && convTimeSel == 3'h0
        |-> gap == 16'(50 * CYC_PER_US)) else $error("bad period");
    conv_idle_a: assert property (
        !enable [*2] |=> !convStart) else $error("pulse while idle");
    result_lat_a: assert property (
        sampleValid && avgSel == 3'h0 |-> ##4 resultValid)
        else $error("result late");
    temp_pass_a: assert property (
        sampleValid && avgSel == 3'h0
        |-> ##2 dieTemperatureResult == $past(sampleTemp, 2))
        else $error("temp wrong");
    zero_cal_a: assert property (
        resultValid && shuntCal == 15'h0000 |-> currentResult == 16'sh0000)
        else $error("current not zero");
    cur_sign_a: assert property (
        resultValid && shuntCal != 15'h0000 && shuntVoltageResult < 0
        |-> currentResult < 0) else $error("current sign lost");
    over_temp_a: assert property (
        resultValid |-> overTemperature == (dieTemperatureResult
        > $past(temperatureLimitThreshold))) else $error("temp flag");
    over_power_a: assert property (
        resultValid |-> overPower == (powerResult
        > {$past(powerLimitThreshold), 8'h00})) else $error("power flag");
    power_follow_a: assert property (
        $changed(powerResult) |-> ##1 resultValid) else $error("power late");
    cur_follow_a: assert property (
        $changed(currentResult) |-> ##2 resultValid)
        else $error("current late");
endmodule

bind pmrs_result_scaling pmrs_result_scaling_monitor #(
    .CYC_PER_US(CYC_PER_US)
) u_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .enable(enable),
    .convTimeSel(convTimeSel), .avgSel(avgSel), .shuntCal(shuntCal),
    .temperatureLimitThreshold(temperatureLimitThreshold),
    .powerLimitThreshold(powerLimitThreshold), .convStart(convStart),
    .sampleValid(sampleValid), .sampleTemp(sampleTemp),
    .shuntVoltageResult(shuntVoltageResult),
    .dieTemperatureResult(dieTemperatureResult),
    .currentResult(currentResult), .powerResult(powerResult),
    .resultValid(resultValid), .overTemperature(overTemperature),
    .overPower(overPower)
);

//--- dv/test_pmrs_result_scaling.sv
`timescale 1ns/10ps
module test_pmrs_result_scaling;
    logic               core_clk, rst_n, enable, inputRangeSelect;
    logic               convStart, sampleValid, resultValid;
    logic               overTemp, overPow;
    logic [2:0]         convTimeSel, avgSel;
    logic [3:0]         delayCyc;
    logic [14:0]        shuntCal;
    logic [15:0]        powerLimit, busRes, sampleBus, busIn;
    logic [17:0]        sampleShunt, shuntIn;
    logic [11:0]        sampleTemp, tempIn;
    logic [23:0]        powRes;
    logic signed [11:0] tempLimit, tempRes;
    logic signed [15:0] shuntRes, curRes;
    int                 err_count, n_checks;

    pmrs_result_scaling #(.CYC_PER_US(1)) u_pmrs_result_scaling (
        .core_clk(core_clk), .rst_n(rst_n), .enable(enable),
        .inputRangeSelect(inputRangeSelect), .convTimeSel(convTimeSel),
        .avgSel(avgSel), .shuntCal(shuntCal),
        .temperatureLimitThreshold(tempLimit),
        .powerLimitThreshold(powerLimit), .convStart(convStart),
        .sampleValid(sampleValid), .sampleShunt(sampleShunt),
        .sampleBus(sampleBus), .sampleTemp(sampleTemp),
        .shuntVoltageResult(shuntRes), .busVoltageResult(busRes),
        .dieTemperatureResult(tempRes), .currentResult(curRes),
        .powerResult(powRes), .resultValid(resultValid),
        .overTemperature(overTemp), .overPower(overPow));
    pmrs_adc_model u_pmrs_adc_model (
        .core_clk(core_clk), .rst_n(rst_n), .convStart(convStart),
        .delayCyc(delayCyc), .shuntIn(shuntIn), .busIn(busIn),
        .tempIn(tempIn), .sampleValid(sampleValid),
        .sampleShunt(sampleShunt), .sampleBus(sampleBus),
        .sampleTemp(sampleTemp));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic logic signed [15:0] sat16(input longint v);
        if (v > 32767)
            return 16'sh7FFF;
        if (v < -32768)
            return 16'sh8000;
        return 16'(v);
    endfunction

    // 0 conversion request, 1 sample, 2 result; n hits 400 if none came
    task automatic wait_for(input int which, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while ((which == 0 ? convStart : which == 1 ? sampleValid
                    : resultValid) !== 1'b1 && n < 400);
    endtask

    task automatic run_one(input logic rng, input logic signed [17:0] raw,
                           input logic signed [15:0] bus,
                           input logic signed [11:0] tmp,
                           input logic [14:0] cal);
        logic signed [15:0] sh, cur;
        logic [15:0]        bv;
        longint             p;
        logic [23:0]        pw;
        int                 n;
        @(posedge core_clk);
        inputRangeSelect <= rng;
        shuntIn          <= raw;
        busIn            <= bus;
        tempIn           <= tmp;
        shuntCal         <= cal;
        enable           <= 1'b1;
        wait_for(2, n);
        sh = rng ? sat16(raw) : 16'(raw >>> 2);
        cur = sat16((longint'(sh) * longint'(cal)) >>> 11);
        bv = (bus < 0) ? 16'h0000 : bus;
        p = ((cur < 0) ? -longint'(cur) : longint'(cur)) * longint'(bv) >> 6;
        pw = (p > 16777215) ? 24'hFFFFFF : 24'(p);
        check("shunt", shuntRes, sh);
        check("bus", busRes, bv);
        check("temp", tempRes, tmp);
        check("current", curRes, cur);
        check("power", powRes, pw);
        check("overTemp", overTemp, tmp > tempLimit);
        check("overPow", overPow, pw > {powerLimit, 8'h00});
        @(posedge core_clk);
        enable <= 1'b0;
    endtask

    task automatic t_conv;
        int n;
        for (int s = 0; s < 3; s++) begin
            @(posedge core_clk);
            enable      <= 1'b0;
            convTimeSel <= 3'(s);
            @(posedge core_clk);
            enable <= 1'b1;
            wait_for(0, n);
            wait_for(0, n);
            check("period", 24'(n), s == 0 ? 24'h000032 : s == 1 ?
                  24'h000054 : 24'h000096);
        end
        @(posedge core_clk);
        enable <= 1'b0;
        wait_for(0, n);
        check("idle", 24'(n), 24'h000190);
    endtask

    task automatic t_scaling;
        run_one(1'b0, -18'sh00005, 16'sh1000, 12'shF00, 15'h0800);
        run_one(1'b0, 18'sh1FFFF, 16'sh8000, 12'sh800, 15'h7FFF);
        run_one(1'b1, 18'sh20000, 16'sh7FFF, 12'sh7FF, 15'h7FFF);
        run_one(1'b1, 18'sh00FA0, 16'sh0640, 12'sh0C8, 15'h0400);
        run_one(1'b0, 18'sh0FA00, 16'sh2000, 12'sh010, 15'h0000);
    endtask

    task automatic t_flags;
        @(posedge core_clk);
        tempLimit  <= 12'sh0C8;
        powerLimit <= 16'h00C3;
        run_one(1'b1, 18'sh00FA0, 16'sh0640, 12'sh0C9, 15'h0400);
        run_one(1'b1, 18'sh00FA0, 16'sh0640, 12'sh0C8, 15'h0400);
        @(posedge core_clk);
        powerLimit <= 16'h00C4;
        run_one(1'b1, 18'sh00FA0, 16'sh0640, 12'sh800, 15'h0400);
    endtask

    task automatic t_avg;
        logic signed [17:0] v [4];
        int                 n;
        v = '{18'sh00004, 18'sh00008, -18'sh0000C, -18'sh00007};
        @(posedge core_clk);
        avgSel   <= 3'h1;
        delayCyc <= 4'h9;
        shuntCal <= 15'h0800;
        shuntIn  <= v[0];
        enable   <= 1'b1;
        for (int i = 1; i < 4; i++) begin
            wait_for(1, n);
            // a single-sample result would pulse four edges later
            repeat (4) @(posedge core_clk);
            #1;
            check("early", resultValid, 1'b0);
            @(posedge core_clk);
            shuntIn <= v[i];
        end
        wait_for(2, n);
        check("avgShunt", shuntRes, 16'shFFFE);
        check("avgCurrent", curRes, 16'shFFFE);
        @(posedge core_clk);
        enable <= 1'b0;
        avgSel <= 3'h0;
    endtask

    initial begin
        #(20000 * 5);
        err_count++;
        stop_test();
    end

    initial begin
        err_count = 0;
        n_checks = 0;
        rst_n = 1'b0;
        enable = 1'b0;
        inputRangeSelect = 1'b1;
        convTimeSel = 3'h0;
        avgSel = 3'h0;
        delayCyc = 4'h0;
        shuntCal = 15'h0000;
        tempLimit = 12'sh7FF;
        powerLimit = 16'hFFFF;
        shuntIn = 18'h00000;
        busIn = 16'h0000;
        tempIn = 12'h000;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_conv();
        t_scaling();
        t_flags();
        t_avg();
        stop_test();
    end
endmodule

//--- include/pmrs_pkg.sv
package pmrs_pkg;
    // result and sample widths
    localparam int SHUNT_W      = 16;
    localparam int BUS_W        = 16;
    localparam int TEMP_W       = 12;
    localparam int RAW_SHUNT_W  = 18;
    localparam int CAL_W        = 15;
    localparam int POWER_W      = 24;
    localparam int POL_W        = 16;
    localparam int AVG_W        = 18;
    localparam int NUM_CHAN     = 3;
    localparam int ACC_EXTRA    = 10;
    localparam int TIMER_W      = 24;

    // channel slots in the averager bank
    localparam int CH_SHUNT     = 0;
    localparam int CH_BUS       = 1;
    localparam int CH_TEMP      = 2;

    // raw shunt sample is 1.25 uV/step; wide range drops two bits to 5 uV
    localparam int WIDE_RANGE_SHIFT = 2;

    // 819.2e6 internal factor folds into a divide by 2^11
    localparam real CAL_FIXED_FACTOR = 819.2e6;
    localparam int  CURR_SHIFT       = 11;
    // 3.125 mV bus step over 0.2 current step gives divide by 2^6
    localparam int  POWER_SHIFT      = 6;
    // power limit step is 256 power steps
    localparam int  POL_SHIFT        = 8;

    localparam logic signed [SHUNT_W-1:0] CURR_MAX = 16'sh7FFF;
    localparam logic signed [SHUNT_W-1:0] CURR_MIN = 16'sh8000;
    localparam logic [POWER_W-1:0]        POWER_MAX = 24'hFFFFFF;

    // clock rate and conversion time table in microseconds
    localparam int CLK_FREQ_HZ  = 200_000_000;
    localparam int HZ_PER_MHZ   = 1_000_000;

    function automatic int conv_time_us(input logic [2:0] sel);
        case (sel)
            3'h0:    return 50;
            3'h1:    return 84;
            3'h2:    return 150;
            3'h3:    return 280;
            3'h4:    return 540;
            3'h5:    return 1052;
            3'h6:    return 2074;
            default: return 4120;
        endcase
    endfunction

    // averaging count as log2: 1,4,16,64,128,256,512,1024
    function automatic logic [3:0] avg_log2(input logic [2:0] sel);
        case (sel)
            3'h0:    return 4'h0;
            3'h1:    return 4'h2;
            3'h2:    return 4'h4;
            3'h3:    return 4'h6;
            3'h4:    return 4'h7;
            3'h5:    return 4'h8;
            3'h6:    return 4'h9;
            default: return 4'hA;
        endcase
    endfunction
endpackage

//--- verilog/pmrs_averager.sv
`timescale 1ns/10ps
module pmrs_averager #(
    parameter int W = pmrs_pkg::AVG_W
) (
    input  wire logic                core_clk,  // system clock
    input  wire logic                rst_n,     // async reset, active low
    input  wire logic                inValid,   // one sample per pulse
    input  wire logic signed [W-1:0] inData,    // signed sample
    input  wire logic [3:0]          shiftSel,  // log2 of sample count
    output logic                     outValid,  // pulse, averaged value ready
    output logic signed [W-1:0]      outData    // averaged value
);
    localparam int AW = W + pmrs_pkg::ACC_EXTRA;

    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] next_acc;
    logic [pmrs_pkg::ACC_EXTRA:0] count;
    logic [pmrs_pkg::ACC_EXTRA:0] next_count;
    logic                 next_outValid;
    logic signed [W-1:0]  next_outData;
    logic signed [AW-1:0] sum;
    logic [pmrs_pkg::ACC_EXTRA:0] lastCount;

    always_comb begin
        sum           = acc + AW'(inData);
        lastCount     = (pmrs_pkg::ACC_EXTRA+1)'(1) << shiftSel;
        lastCount     = lastCount - (pmrs_pkg::ACC_EXTRA+1)'(1);
        next_acc      = acc;
        next_count    = count;
        next_outValid = 1'b0;
        next_outData  = outData;
        if (inValid) begin
            if (count >= lastCount) begin
                // truncating shift: floor of the mean, cheap for all counts
                next_outData  = W'(sum >>> shiftSel);
                next_outValid = 1'b1;
                next_acc      = '0;
                next_count    = '0;
            end else begin
                next_acc   = sum;
                next_count = count + (pmrs_pkg::ACC_EXTRA+1)'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc      <= '0;
            count    <= '0;
            outValid <= 1'b0;
            outData  <= '0;
        end else begin
            acc      <= next_acc;
            count    <= next_count;
            outValid <= next_outValid;
            outData  <= next_outData;
        end
    end
endmodule

//--- verilog/pmrs_result_scaling.sv
`timescale 1ns/10ps
module pmrs_result_scaling #(
    parameter int CYC_PER_US = pmrs_pkg::CLK_FREQ_HZ / pmrs_pkg::HZ_PER_MHZ
) (
    input  wire logic                      core_clk,         // 200 MHz clock
    input  wire logic                      rst_n,            // async, low
    input  wire logic                      enable,           // run conversions
    input  wire logic                      inputRangeSelect, // 1 = narrow
    input  wire logic [2:0]                convTimeSel,      // conv time code
    input  wire logic [2:0]                avgSel,           // averaging code
    input  wire logic [pmrs_pkg::CAL_W-1:0] shuntCal,        // calibration
    input  wire logic signed [pmrs_pkg::TEMP_W-1:0]
                                           temperatureLimitThreshold, // limit
    input  wire logic [pmrs_pkg::POL_W-1:0] powerLimitThreshold, // limit
    output logic                           convStart,        // pulse to ADC
    input  wire logic                      sampleValid,      // ADC sample pulse
    input  wire logic signed [pmrs_pkg::RAW_SHUNT_W-1:0]
                                           sampleShunt,      // 1.25 uV step
    input  wire logic signed [pmrs_pkg::BUS_W-1:0]
                                           sampleBus,        // 3.125 mV step
    input  wire logic signed [pmrs_pkg::TEMP_W-1:0]
                                           sampleTemp,       // 125 mC step
    output logic signed [pmrs_pkg::SHUNT_W-1:0]
                                           shuntVoltageResult, // shunt
    output logic [pmrs_pkg::BUS_W-1:0]     busVoltageResult,   // bus
    output logic signed [pmrs_pkg::TEMP_W-1:0]
                                           dieTemperatureResult, // temp
    output logic signed [pmrs_pkg::SHUNT_W-1:0]
                                           currentResult,    // current
    output logic [pmrs_pkg::POWER_W-1:0]   powerResult,      // power
    output logic                           resultValid,      // pulse, all set
    output logic                           overTemperature,  // level
    output logic                           overPower         // level
);
    localparam int AW  = pmrs_pkg::AVG_W;
    localparam int NC  = pmrs_pkg::NUM_CHAN;
    localparam int TW  = pmrs_pkg::TIMER_W;
    localparam int SW  = pmrs_pkg::SHUNT_W;
    localparam int PW  = pmrs_pkg::POWER_W;
    localparam int PRW = 2 * SW;

    typedef enum logic [1:0] {
        STAGE_IDLE,
        STAGE_POWER,
        STAGE_DONE
    } pmrs_stage_t;

    // conversion timer
    logic [TW-1:0] timer;
    logic [TW-1:0] next_timer;
    logic [TW-1:0] period;
    logic          next_convStart;

    always_comb begin
        period         = TW'(pmrs_pkg::conv_time_us(convTimeSel) * CYC_PER_US);
        next_timer     = timer;
        next_convStart = 1'b0;
        if (!enable) begin
            next_timer = '0;
        end else if (timer >= period - TW'(1)) begin
            next_timer     = '0;
            next_convStart = 1'b1;
        end else begin
            next_timer = timer + TW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer     <= '0;
            convStart <= 1'b0;
        end else begin
            timer     <= next_timer;
            convStart <= next_convStart;
        end
    end

    // averager bank, one per channel
    logic signed [AW-1:0] avgIn  [NC];
    logic signed [AW-1:0] avgOut [NC];
    logic [NC-1:0]        avgValid;

    assign avgIn[pmrs_pkg::CH_SHUNT] = sampleShunt;
    assign avgIn[pmrs_pkg::CH_BUS]   = AW'(sampleBus);
    assign avgIn[pmrs_pkg::CH_TEMP]  = AW'(sampleTemp);

    genvar ch;
    generate
        for (ch = 0; ch < NC; ch++) begin : g_avg
            pmrs_averager #(
                .W        (AW)
            ) u_avg (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .inValid  (sampleValid),
                .inData   (avgIn[ch]),
                .shiftSel (pmrs_pkg::avg_log2(avgSel)),
                .outValid (avgValid[ch]),
                .outData  (avgOut[ch])
            );
        end
    endgenerate

    // result pipeline
    pmrs_stage_t             stage;
    pmrs_stage_t             next_stage;
    logic signed [SW-1:0]    next_shunt;
    logic [SW-1:0]           next_bus;
    logic signed [pmrs_pkg::TEMP_W-1:0] next_temp;
    logic signed [SW-1:0]    next_current;
    logic [PW-1:0]           next_power;
    logic                    next_resultValid;
    logic                    next_overTemp;
    logic                    next_overPower;
    logic signed [AW-1:0]    rawShunt;
    logic signed [AW-1:0]    rawBus;
    logic signed [AW-1:0]    wideShunt;
    logic signed [PRW-1:0]   curProd;
    logic signed [PRW-1:0]   curScaled;
    logic [SW-1:0]           curMag;
    logic [PRW-1:0]          pwrProd;
    logic [PRW-1:0]          pwrScaled;
    logic [PW-1:0]           polScaled;

    // sign-extended bounds for the narrow-range clamp
    localparam logic signed [AW-1:0] CURR_MAX_EXT = AW'(pmrs_pkg::CURR_MAX);
    localparam logic signed [AW-1:0] CURR_MIN_EXT = AW'(pmrs_pkg::CURR_MIN);

    always_comb begin
        next_stage       = stage;
        next_shunt       = shuntVoltageResult;
        next_bus         = busVoltageResult;
        next_temp        = dieTemperatureResult;
        next_current     = currentResult;
        next_power       = powerResult;
        next_resultValid = 1'b0;
        next_overTemp    = overTemperature;
        next_overPower   = overPower;
        rawShunt         = avgOut[pmrs_pkg::CH_SHUNT];
        rawBus           = avgOut[pmrs_pkg::CH_BUS];
        wideShunt        = rawShunt >>> pmrs_pkg::WIDE_RANGE_SHIFT;

        if (!inputRangeSelect) begin
            next_shunt = SW'(wideShunt);
        end else if (rawShunt > AW'(CURR_MAX_EXT)) begin
            next_shunt = pmrs_pkg::CURR_MAX;
        end else if (rawShunt < AW'(CURR_MIN_EXT)) begin
            next_shunt = pmrs_pkg::CURR_MIN;
        end else begin
            next_shunt = SW'(rawShunt);
        end

        curProd   = PRW'(next_shunt) * PRW'($signed({1'b0, shuntCal}));
        curScaled = curProd >>> pmrs_pkg::CURR_SHIFT;

        curMag    = currentResult[SW-1] ? SW'(-currentResult)
                                        : SW'(currentResult);
        pwrProd   = PRW'(curMag) * PRW'(busVoltageResult);
        pwrScaled = pwrProd >> pmrs_pkg::POWER_SHIFT;
        polScaled = PW'(powerLimitThreshold) << pmrs_pkg::POL_SHIFT;

        case (stage)
            STAGE_IDLE: begin
                if (avgValid[pmrs_pkg::CH_SHUNT]) begin
                    next_bus  = rawBus[AW-1] ? '0 : SW'(rawBus);
                    next_temp = pmrs_pkg::TEMP_W'(avgOut[pmrs_pkg::CH_TEMP]);
                    if (shuntCal == '0) begin
                        next_current = '0;
                    end else if (curScaled > PRW'(pmrs_pkg::CURR_MAX)) begin
                        next_current = pmrs_pkg::CURR_MAX;
                    end else if (curScaled < PRW'(pmrs_pkg::CURR_MIN)) begin
                        next_current = pmrs_pkg::CURR_MIN;
                    end else begin
                        next_current = SW'(curScaled);
                    end
                    next_stage = STAGE_POWER;
                end
            end
            STAGE_POWER: begin
                if (pwrScaled > PRW'(pmrs_pkg::POWER_MAX)) begin
                    next_power = pmrs_pkg::POWER_MAX;
                end else begin
                    next_power = PW'(pwrScaled);
                end
                next_stage = STAGE_DONE;
            end
            STAGE_DONE: begin
                next_overTemp    = dieTemperatureResult >
                                   temperatureLimitThreshold;
                next_overPower   = powerResult > polScaled;
                next_resultValid = 1'b1;
                next_stage       = STAGE_IDLE;
            end
            default: begin
                next_stage = STAGE_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage                <= STAGE_IDLE;
            shuntVoltageResult   <= '0;
            busVoltageResult     <= '0;
            dieTemperatureResult <= '0;
            currentResult        <= '0;
            powerResult          <= '0;
            resultValid          <= 1'b0;
            overTemperature      <= 1'b0;
            overPower            <= 1'b0;
        end else begin
            stage                <= next_stage;
            shuntVoltageResult   <= next_shunt;
            busVoltageResult     <= next_bus;
            dieTemperatureResult <= next_temp;
            currentResult        <= next_current;
            powerResult          <= next_power;
            resultValid          <= next_resultValid;
            overTemperature      <= next_overTemp;
            overPower            <= next_overPower;
        end
    end
endmodule
